// *** common/sta_pkg.sv ***
// package: constants and types for symbol timing, latency and alignment control
package sta_pkg;
	// ------------------------------------------------------------
	// structure of the modulator
	// ------------------------------------------------------------
	localparam int NUM_CH = 128;
	localparam int NUM_COMB = 16;
	localparam int NUM_BLOCK = 4;
	localparam int NUM_GEN = 4;
	localparam int NUM_PD = 4;
	localparam int CH_PER_COMB = 8;
	localparam int CH_PER_BLOCK = 32;
	localparam int COMB_PER_BLOCK = 4;
	localparam int CH_IDX_W = 7;
	localparam int GEN_IDX_W = 2;
	localparam int RATE_W = 16;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam int ADR_W = 12;
	localparam int ADR_LSB = 2;
	localparam logic [9:0] IDX_CHAN_SEL = 10'h000;
	localparam logic [9:0] IDX_CHAN_CFG = 10'h001;
	localparam logic [9:0] IDX_STATUS = 10'h002;
	localparam logic [9:0] IDX_LAT_CTRL = 10'h003;
	localparam logic [9:0] IDX_COMB_CFG = 10'h004;
	localparam logic [9:0] IDX_SYNC_CFG = 10'h005;
	localparam logic [9:0] IDX_PD_DELAY = 10'h006;
	localparam logic [9:0] IDX_BLOCK_CFG = 10'h007;
	localparam logic [9:0] IDX_RATE0 = 10'h008;
	localparam logic [9:0] IDX_LAT_RESULT = 10'h00C;
	localparam logic [9:0] IDX_LAT_UNC = 10'h00D;
	localparam logic [9:0] IDX_PD_CTRL = 10'h081;

	// ------------------------------------------------------------
	// field layouts and reset values
	// ------------------------------------------------------------
	localparam int CH_CFG_W = 10;
	localparam int CH_SYM_LSB = 0;
	localparam int CH_SYM_W = 4;
	localparam int CH_HALF_BIT = 4;
	localparam int CH_QTR_BIT = 5;
	localparam int CH_MUTE_BIT = 6;
	localparam int CH_SYNC_BIT = 7;
	localparam int CH_GEN_LSB = 8;
	localparam logic [3:0] CH_SYM_MAX = 4'hC;
	localparam int COMB_FINE_LSB = 16;
	localparam int PD_DLY_W = 4;
	localparam int PD_D1_LSB = 0;
	localparam int PD_D2_LSB = 4;
	localparam int PD_D3_LSB = 8;
	localparam int PD_GATE_LSB = 7;
	localparam logic [3:0] PD_D1_RST = 4'h1;
	localparam logic [3:0] PD_D2_RST = 4'hC;
	localparam logic [3:0] PD_D3_RST = 4'hC;
	localparam int PD_D3_RST_CLKS = 192;
	localparam int PD_UNIT_CLKS = PD_D3_RST_CLKS / 12;
	localparam int LAT_START_BIT = 0;
	localparam int LAT_D4_LSB = 4;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RATIO_INT_BIT = 1;
	localparam int ST_LAT_VALID_BIT = 2;
	localparam int ST_CH_SYNCED_BIT = 3;
	localparam int RATE_DEN_LSB = 16;
	localparam logic [15:0] RATE_RST = 16'h0001;

	// ------------------------------------------------------------
	// clock ratios: data clock is two master clocks, div16 is 16 data clocks
	// ------------------------------------------------------------
	localparam int CLK_PER_HALF_RATE_DATA_CLOCK = 2;
	localparam int HALF_RATE_DATA_CLOCK_PER_D16 = 16;
	localparam int CLK_PER_D16 = CLK_PER_HALF_RATE_DATA_CLOCK * HALF_RATE_DATA_CLOCK_PER_D16;
	localparam int DIV_CNT_W = 5;
	localparam logic [4:0] DIV_LAST = 5'(CLK_PER_D16 - 1);

	// ------------------------------------------------------------
	// latency figures in master clock periods
	// ------------------------------------------------------------
	localparam int LAT_SYM_BASE = 12480;
	localparam int LAT_W_D1 = 256;
	localparam int LAT_W_D2 = 128;
	localparam int LAT_W_D3 = 64;
	localparam int SYM_UPSAMPLE = 512;
	localparam int LAT_CC_BASE = 19968;
	localparam int LAT_W_D5 = 512;
	localparam int LAT_W_D6 = 256;
	localparam int LAT_DAC = 11;
	localparam int LAT_UNC = 512;
	localparam int DIV_W = 48;
	localparam logic [5:0] DIV_STEPS = 6'(DIV_W);

	typedef enum {LAT_IDLE, LAT_DIV_RATIO, LAT_DIV_SYM, LAT_SUM} lat_state_t;
endpackage

// *** rtl/symbol_rate_gen.sv ***
// symbol rate generator: fractional numerator/denominator read strobe on div16 ticks
`timescale 1ns/1ps
`default_nettype none
module symbol_rate_gen
	import sta_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// timing
	input wire logic div16En,
	input wire logic syncEdge,
	// configuration
	input wire logic [RATE_W-1:0] numerator,
	input wire logic [RATE_W-1:0] denominator,
	input wire logic alignEn,
	// result
	output logic symbolRead
);
	logic [RATE_W:0] acc_r;
	logic [RATE_W:0] acc_nxt;

	// ------------------------------------------------------------
	// accumulate denominator per tick; a wrap past the numerator reads
	// ------------------------------------------------------------
	// a non-integer ratio makes the read spacing alternate by one tick
	assign acc_nxt = acc_r + {1'b0, denominator};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_r <= '0;
			symbolRead <= 1'b0;
		end else if (div16En && syncEdge && alignEn) begin
			acc_r <= '0;
			symbolRead <= 1'b1;
		end else if (div16En && acc_nxt >= {1'b0, numerator}) begin
			acc_r <= acc_nxt - {1'b0, numerator};
			symbolRead <= 1'b1;
		end else if (div16En) begin
			acc_r <= acc_nxt;
			symbolRead <= 1'b0;
		end else begin
			symbolRead <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** rtl/symbol_timing_alignment_ctrl.sv ***
// symbol timing, latency, alignment and power gating control of the modulator
//
// Functional notes
// - non-integer rate ratio shifts symbol reads by one div16 tick either way
// - ratio jitter uncertainty is one div16 tick; zero for integer ratio
// - latency = symbol latency*512 + combiner latency +/-512 + 11
// - symbol latency = (12480+256*d1+128*d2+64*d3+d4) divided by ratio
// - combiner latency = 19968+512*coarse+256*fine+predistortion third delay
// - predistortion third delay resets to 192 master clocks
// - 128 channels: symbol delay 0..12, half and quarter symbol delay bits
// - 16 combiners each have a coarse and a fine one-bit delay
// - three predistortion delays 0..15, resetting to 1, 12, 12
// - half-rate data clock is two master clocks; conversions use it
// - muting a synchronised channel drops its synchronisation
// - aligned FIFO groups release read pointers together on the sync edge
// - no alignment signal or feedback goes back to the aligner
// - sync strobe synchronised into div16 timing, rising edge acted on
// - each rate generator's alignment to sync is enabled separately
// - global reset clears configuration registers; predistortion delays load 1, 12, 12 and rates load 1
// - held reset stops the internal clock dividers
// - muting gates the channel symbol path clock; zero gain does not
// - each 32-channel block combiner can be shut down separately
// - four predistortion branches clock after reset, gated by 0x081 bits 10:7
`timescale 1ns/1ps
`default_nettype none
module symbol_timing_alignment_ctrl
	import sta_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sync strobe pin
	input wire logic syncStrobeIn,
	// derived timing
	output logic halfRateTick,
	output logic div16Tick,
	// symbol read side
	output logic [NUM_GEN-1:0] symbolRead,
	output logic [NUM_GEN-1:0] fifoRelease,
	output logic [NUM_CH-1:0] channelSynced,
	// power gating
	output logic [NUM_CH-1:0] channelClkEn,
	output logic [NUM_COMB-1:0] combClkEn,
	output logic [NUM_BLOCK-1:0] blockClkEn,
	output logic [NUM_PD-1:0] pdBranchClkEn,
	// delay settings
	output logic [NUM_COMB-1:0] combCoarseDelay,
	output logic [NUM_COMB-1:0] combFineDelay,
	output logic [3*PD_DLY_W-1:0] pdDelay
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [DIV_CNT_W-1:0] divCnt_r;
	logic div16En;
	logic syncMeta_r;
	logic syncSync_r;
	logic syncLast_r;
	logic syncEdge;
	logic [CH_IDX_W-1:0] chanSel_r;
	logic [CH_CFG_W-1:0] chanCfg_r [NUM_CH];
	logic [NUM_COMB-1:0] combCoarse_r;
	logic [NUM_COMB-1:0] combFine_r;
	logic [NUM_GEN-1:0] alignEn_r;
	logic [PD_DLY_W-1:0] pdD1_r;
	logic [PD_DLY_W-1:0] pdD2_r;
	logic [PD_DLY_W-1:0] pdD3_r;
	logic [NUM_BLOCK-1:0] blockOff_r;
	logic [NUM_PD-1:0] pdGate_r;
	logic [RATE_W-1:0] rateNum_r [NUM_GEN];
	logic [RATE_W-1:0] rateDen_r [NUM_GEN];
	logic [3:0] latD4_r;
	logic [NUM_GEN-1:0] releaseNow;
	logic wbReq;
	logic wbWrite;
	logic [9:0] wbIdx;
	logic [31:0] readMux;
	logic [31:0] wrVal;
	lat_state_t latState_r;
	logic [DIV_W-1:0] divQ_r;
	logic [RATE_W:0] divR_r;
	logic [RATE_W-1:0] divD_r;
	logic [5:0] divCnt2_r;
	logic [RATE_W:0] remShift;
	logic ratioInt_r;
	logic latValid_r;
	logic [31:0] latency_r;
	logic [CH_CFG_W-1:0] selCfg;
	logic [GEN_IDX_W-1:0] selGen;
	logic [3:0] selComb;
	logic [31:0] latSymBase;
	logic [31:0] latCc;
	logic latStart;

	// ------------------------------------------------------------
	// clock dividers: data clock and div16 enables from the master clock
	// ------------------------------------------------------------
	// counter is held at zero during reset so no divided tick is produced
	always_ff @(posedge clk) begin
		if (!resetn) begin
			divCnt_r <= '0;
		end else begin
			divCnt_r <= divCnt_r + 5'h01;
		end
	end

	assign div16En = resetn && (divCnt_r == DIV_LAST);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			halfRateTick <= 1'b0;
			div16Tick <= 1'b0;
		end else begin
			halfRateTick <= divCnt_r[0];
			div16Tick <= div16En;
		end
	end

	// ------------------------------------------------------------
	// sync strobe: two-flop synchroniser, edge taken on div16 ticks
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncMeta_r <= 1'b0;
			syncSync_r <= 1'b0;
		end else begin
			syncMeta_r <= syncStrobeIn;
			syncSync_r <= syncMeta_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncLast_r <= 1'b0;
		end else if (div16En) begin
			syncLast_r <= syncSync_r;
		end
	end

	// the strobe only steers internal timing; nothing is returned to the aligner
	assign syncEdge = div16En && syncSync_r && !syncLast_r;

	// ------------------------------------------------------------
	// rate generators and grouped fifo release
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_GEN; g++) begin : genRate
			assign releaseNow[g] = syncEdge && alignEn_r[g];

			symbol_rate_gen uGen (
				.clk(clk),
				.resetn(resetn),
				.div16En(div16En),
				.syncEdge(syncEdge),
				.numerator(rateNum_r[g]),
				.denominator(rateDen_r[g]),
				.alignEn(alignEn_r[g]),
				.symbolRead(symbolRead[g])
			);
		end
	endgenerate

	// every enabled group sees the release in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fifoRelease <= '0;
		end else begin
			fifoRelease <= releaseNow;
		end
	end

	// ------------------------------------------------------------
	// per-channel clock gating and synchronised state
	// ------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : genChan
			always_ff @(posedge clk) begin
				if (!resetn) begin
					channelClkEn[c] <= 1'b0;
					channelSynced[c] <= 1'b0;
				end else begin
					// gain is not looked at: zero gain keeps the clock running
					channelClkEn[c] <= !chanCfg_r[c][CH_MUTE_BIT]
						&& !blockOff_r[c / CH_PER_BLOCK];
					if (chanCfg_r[c][CH_MUTE_BIT]) begin
						channelSynced[c] <= 1'b0;
					end else if (chanCfg_r[c][CH_SYNC_BIT]
						&& releaseNow[chanCfg_r[c][CH_GEN_LSB +: GEN_IDX_W]]) begin
						channelSynced[c] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	genvar k;
	generate
		for (k = 0; k < NUM_COMB; k++) begin : genComb
			always_ff @(posedge clk) begin
				if (!resetn) begin
					combClkEn[k] <= 1'b0;
				end else begin
					combClkEn[k] <= !blockOff_r[k / COMB_PER_BLOCK];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!resetn) begin
			blockClkEn <= '0;
			pdBranchClkEn <= '0;
			combCoarseDelay <= '0;
			combFineDelay <= '0;
			pdDelay <= '0;
		end else begin
			blockClkEn <= ~blockOff_r;
			pdBranchClkEn <= ~pdGate_r;
			combCoarseDelay <= combCoarse_r;
			combFineDelay <= combFine_r;
			pdDelay <= {pdD3_r, pdD2_r, pdD1_r};
		end
	end

	// ------------------------------------------------------------
	// wishbone slave: one wait state, unmapped reads return zero
	// ------------------------------------------------------------
	assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wbWrite = wbReq && wb_we_i;
	assign wbIdx = wb_adr_i[ADR_W-1:ADR_LSB];
	assign selCfg = chanCfg_r[chanSel_r];

	always_comb begin
		readMux = 32'h0000_0000;
		if (wbIdx == IDX_CHAN_SEL) begin
			readMux[CH_IDX_W-1:0] = chanSel_r;
		end else if (wbIdx == IDX_CHAN_CFG) begin
			readMux[CH_CFG_W-1:0] = selCfg;
		end else if (wbIdx == IDX_STATUS) begin
			readMux[ST_BUSY_BIT] = (latState_r != LAT_IDLE);
			readMux[ST_RATIO_INT_BIT] = ratioInt_r;
			readMux[ST_LAT_VALID_BIT] = latValid_r;
			readMux[ST_CH_SYNCED_BIT] = channelSynced[chanSel_r];
		end else if (wbIdx == IDX_LAT_CTRL) begin
			readMux[LAT_D4_LSB +: 4] = latD4_r;
		end else if (wbIdx == IDX_COMB_CFG) begin
			readMux = {combFine_r, combCoarse_r};
		end else if (wbIdx == IDX_SYNC_CFG) begin
			readMux[NUM_GEN-1:0] = alignEn_r;
		end else if (wbIdx == IDX_PD_DELAY) begin
			readMux[3*PD_DLY_W-1:0] = {pdD3_r, pdD2_r, pdD1_r};
		end else if (wbIdx == IDX_BLOCK_CFG) begin
			readMux[NUM_BLOCK-1:0] = blockOff_r;
		end else if (wbIdx[9:2] == IDX_RATE0[9:2]) begin
			readMux = {rateDen_r[wbIdx[1:0]], rateNum_r[wbIdx[1:0]]};
		end else if (wbIdx == IDX_LAT_RESULT) begin
			readMux = latency_r;
		end else if (wbIdx == IDX_LAT_UNC) begin
			readMux = ratioInt_r ? 32'h0000_0000 : 32'(CLK_PER_D16);
		end else if (wbIdx == IDX_PD_CTRL) begin
			readMux[PD_GATE_LSB +: NUM_PD] = pdGate_r;
		end
	end

	// byte lanes not selected keep their current contents
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wrVal[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : readMux[8*b +: 8];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= wbReq ? readMux : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// configuration registers, all reset by the global reset; predistortion delays and rates load nonzero values
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			chanSel_r <= '0;
			combCoarse_r <= '0;
			combFine_r <= '0;
			alignEn_r <= '0;
			pdD1_r <= PD_D1_RST;
			pdD2_r <= PD_D2_RST;
			pdD3_r <= PD_D3_RST;
			blockOff_r <= '0;
			pdGate_r <= '0;
			latD4_r <= '0;
			for (int r = 0; r < NUM_GEN; r++) begin
				rateNum_r[r] <= RATE_RST;
				rateDen_r[r] <= RATE_RST;
			end
		end else if (wbWrite) begin
			if (wbIdx == IDX_CHAN_SEL) begin
				chanSel_r <= wrVal[CH_IDX_W-1:0];
			end else if (wbIdx == IDX_COMB_CFG) begin
				combCoarse_r <= wrVal[NUM_COMB-1:0];
				combFine_r <= wrVal[COMB_FINE_LSB +: NUM_COMB];
			end else if (wbIdx == IDX_SYNC_CFG) begin
				alignEn_r <= wrVal[NUM_GEN-1:0];
			end else if (wbIdx == IDX_PD_DELAY) begin
				pdD1_r <= wrVal[PD_D1_LSB +: PD_DLY_W];
				pdD2_r <= wrVal[PD_D2_LSB +: PD_DLY_W];
				pdD3_r <= wrVal[PD_D3_LSB +: PD_DLY_W];
			end else if (wbIdx == IDX_BLOCK_CFG) begin
				blockOff_r <= wrVal[NUM_BLOCK-1:0];
			end else if (wbIdx == IDX_PD_CTRL) begin
				pdGate_r <= wrVal[PD_GATE_LSB +: NUM_PD];
			end else if (wbIdx == IDX_LAT_CTRL) begin
				latD4_r <= wrVal[LAT_D4_LSB +: 4];
			end else if (wbIdx[9:2] == IDX_RATE0[9:2]) begin
				rateNum_r[wbIdx[1:0]] <= wrVal[RATE_W-1:0];
				rateDen_r[wbIdx[1:0]] <= wrVal[RATE_DEN_LSB +: RATE_W];
			end
		end
	end

	// symbol delays above the documented top are clamped
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				chanCfg_r[i] <= '0;
			end
		end else if (wbWrite && wbIdx == IDX_CHAN_CFG) begin
			chanCfg_r[chanSel_r] <= wrVal[CH_CFG_W-1:0];
			if (wrVal[CH_SYM_LSB +: CH_SYM_W] > CH_SYM_MAX) begin
				chanCfg_r[chanSel_r][CH_SYM_LSB +: CH_SYM_W] <= CH_SYM_MAX;
			end
		end
	end

	// ------------------------------------------------------------
	// latency calculator for the selected channel
	// ------------------------------------------------------------
	// one shared serial divider: first the ratio test, then the symbol term
	assign selGen = selCfg[CH_GEN_LSB +: GEN_IDX_W];
	assign selComb = chanSel_r[CH_IDX_W-1 -: 4];
	assign latStart = wbWrite && wbIdx == IDX_LAT_CTRL && wrVal[LAT_START_BIT];
	assign remShift = {divR_r[RATE_W-1:0], divQ_r[DIV_W-1]};

	assign latSymBase = 32'(LAT_SYM_BASE)
		+ 32'(LAT_W_D1) * 32'(selCfg[CH_SYM_LSB +: CH_SYM_W])
		+ 32'(LAT_W_D2) * 32'(selCfg[CH_HALF_BIT])
		+ 32'(LAT_W_D3) * 32'(selCfg[CH_QTR_BIT])
		+ 32'(latD4_r);

	assign latCc = 32'(LAT_CC_BASE)
		+ 32'(LAT_W_D5) * 32'(combCoarse_r[selComb])
		+ 32'(LAT_W_D6) * 32'(combFine_r[selComb])
		+ 32'(PD_UNIT_CLKS) * 32'(pdD3_r);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			latState_r <= LAT_IDLE;
			divQ_r <= '0;
			divR_r <= '0;
			divD_r <= '0;
			divCnt2_r <= '0;
			ratioInt_r <= 1'b0;
			latValid_r <= 1'b0;
			latency_r <= 32'h0000_0000;
		end else begin
			unique case (latState_r)
				LAT_IDLE: begin
					if (latStart) begin
						latValid_r <= 1'b0;
						divQ_r <= DIV_W'(rateNum_r[selGen]);
						divD_r <= rateDen_r[selGen];
						divR_r <= '0;
						divCnt2_r <= DIV_STEPS;
						latState_r <= LAT_DIV_RATIO;
					end
				end
				LAT_DIV_RATIO, LAT_DIV_SYM: begin
					if (remShift >= {1'b0, divD_r}) begin
						divR_r <= remShift - {1'b0, divD_r};
						divQ_r <= {divQ_r[DIV_W-2:0], 1'b1};
					end else begin
						divR_r <= remShift;
						divQ_r <= {divQ_r[DIV_W-2:0], 1'b0};
					end
					divCnt2_r <= divCnt2_r - 6'h01;
					if (divCnt2_r == 6'h01 && latState_r == LAT_DIV_RATIO) begin
						// symbol term = base * denominator * 512 / numerator
						ratioInt_r <= (remShift - (remShift >= {1'b0, divD_r}
							? {1'b0, divD_r} : '0)) == '0;
						divQ_r <= DIV_W'(latSymBase) * DIV_W'(rateDen_r[selGen])
							* DIV_W'(SYM_UPSAMPLE);
						divD_r <= rateNum_r[selGen];
						divR_r <= '0;
						divCnt2_r <= DIV_STEPS;
						latState_r <= LAT_DIV_SYM;
					end else if (divCnt2_r == 6'h01) begin
						latState_r <= LAT_SUM;
					end
				end
				LAT_SUM: begin
					latency_r <= divQ_r[31:0] + latCc + 32'(LAT_DAC);
					latValid_r <= 1'b1;
					latState_r <= LAT_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** testbench/sta_aligner_model.sv ***
// external aligner model: mirrored divider and zero-count strobe source
`timescale 1ns/1ps
`default_nettype none
module sta_aligner_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// request from the bench
	input wire logic go,
	// strobe pin; nothing comes back from the device
	output logic strobe
);
	// ----
	// mirror of the div16 counter, restarted by the shared reset
	// ----
	logic [4:0] mirCnt_r;
	logic [6:0] hold_r;
	logic armed_r;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mirCnt_r <= 5'h00;
			hold_r <= 7'h00;
			armed_r <= 1'b0;
			strobe <= 1'b0;
		end else begin
			mirCnt_r <= mirCnt_r + 5'h01;
			if (go) begin
				armed_r <= 1'b1;
			end
			// held two mirror periods so the device tick cannot miss it
			if (armed_r && mirCnt_r == 5'h00) begin
				strobe <= 1'b1;
				hold_r <= 7'h3F;
				armed_r <= 1'b0;
			end else if (hold_r != 7'h00) begin
				hold_r <= hold_r - 7'h01;
			end else begin
				strobe <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/symbol_timing_alignment_ctrl_sva.sv ***
// checker: port-level timing and gating assertions
`timescale 1ns/1ps
`default_nettype none
module symbol_timing_alignment_ctrl_sva
	import sta_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// timing and gating
	input wire logic halfRateTick,
	input wire logic div16Tick,
	input wire logic [NUM_GEN-1:0] symbolRead,
	input wire logic [NUM_GEN-1:0] fifoRelease,
	input wire logic [NUM_CH-1:0] channelClkEn,
	input wire logic [NUM_COMB-1:0] combClkEn,
	input wire logic [NUM_BLOCK-1:0] blockClkEn,
	input wire logic [NUM_PD-1:0] pdBranchClkEn,
	input wire logic [3*PD_DLY_W-1:0] pdDelay
);
	// ----
	// assertions
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [3:0] b;
	assign b = blockClkEn;
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse after request");
	property p_dat;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat: assert property (p_dat) else $error("read data outside ack");
	property p_half;
		halfRateTick |=> !halfRateTick;
	endproperty
	a_half: assert property (p_half) else $error("data clock phase stuck");
	property p_d16;
		div16Tick |=> !div16Tick ##31 div16Tick;
	endproperty
	a_d16: assert property (p_d16) else $error("div16 tick not every 32 clocks");
	property p_rel;
		|fifoRelease |-> div16Tick && (symbolRead & fifoRelease) == fifoRelease;
	endproperty
	a_rel: assert property (p_rel) else $error("release off the div16 tick");
	property p_rel1;
		|fifoRelease |=> fifoRelease == 4'h0;
	endproperty
	a_rel1: assert property (p_rel1) else $error("release wider than a pulse");
	property p_read;
		|symbolRead |-> div16Tick;
	endproperty
	a_read: assert property (p_read) else $error("symbol read between ticks");
	property p_comb;
		combClkEn == {{4{b[3]}}, {4{b[2]}}, {4{b[1]}}, {4{b[0]}}};
	endproperty
	a_comb: assert property (p_comb) else $error("combiner enable vs block");
	property p_chan;
		(channelClkEn & ~{{32{b[3]}}, {32{b[2]}}, {32{b[1]}}, {32{b[0]}}}) == '0;
	endproperty
	a_chan: assert property (p_chan) else $error("channel clocked in dead block");
	property p_pdrst;
		$rose(resetn) |-> ##2 pdDelay == 12'hCC1 && pdBranchClkEn == 4'hF;
	endproperty
	a_pdrst: assert property (p_pdrst) else $error("predistortion reset state");
endmodule
bind symbol_timing_alignment_ctrl symbol_timing_alignment_ctrl_sva u_sva (
	.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halfRateTick(halfRateTick),
	.div16Tick(div16Tick), .symbolRead(symbolRead), .fifoRelease(fifoRelease),
	.channelClkEn(channelClkEn), .combClkEn(combClkEn), .blockClkEn(blockClkEn),
	.pdBranchClkEn(pdBranchClkEn), .pdDelay(pdDelay));
`default_nettype wire

// *** testbench/tb_symbol_timing_alignment_ctrl.sv ***
// testbench for the symbol timing and alignment control block
`timescale 1ns/1ps
`default_nettype none
module tb_symbol_timing_alignment_ctrl
	import sta_pkg::*;
;
	// ----
	// signals
	// ----
	logic clk, resetn, cyc, stb, we, syncPin, go, ack, halfTick, d16;
	logic [ADR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] datI, datO;
	logic [NUM_GEN-1:0] symRd, fifoRel;
	logic [NUM_CH-1:0] chSync, chClk;
	logic [NUM_COMB-1:0] combClk, coarse, fine;
	logic [NUM_BLOCK-1:0] blkClk;
	logic [NUM_PD-1:0] pdClk;
	logic [3*PD_DLY_W-1:0] pdDly;
	int failures, compares;
	symbol_timing_alignment_ctrl uut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
		.wb_dat_o(datO), .wb_ack_o(ack), .syncStrobeIn(syncPin), .halfRateTick(halfTick),
		.div16Tick(d16), .symbolRead(symRd), .fifoRelease(fifoRel), .channelSynced(chSync),
		.channelClkEn(chClk), .combClkEn(combClk), .blockClkEn(blkClk),
		.pdBranchClkEn(pdClk), .combCoarseDelay(coarse), .combFineDelay(fine),
		.pdDelay(pdDly));
	sta_aligner_model aligner (.clk(clk), .resetn(resetn), .go(go), .strobe(syncPin));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----
	// shared tasks
	// ----
	task automatic report_and_stop();
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [9:0] i, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= s;
		datI <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk(32'(ack), 32'h0000_0001);
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic [31:0] q;
		wb(1'b1, i, d, s, q);
	endtask
	task automatic rd(input logic [9:0] i, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, i, 32'h0000_0000, 4'hF, q);
		chk(q, e);
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	function automatic logic [31:0] el(int s, int n, int d, int c);
		return 32'(s * d * SYM_UPSAMPLE / n + LAT_CC_BASE + c + LAT_DAC);
	endfunction
	// ----
	// scenarios
	// ----
	task automatic t_defaults();
		rd(IDX_PD_DELAY, 32'h0000_0CC1);
		rd(IDX_PD_CTRL, 32'h0000_0000);
		rd(IDX_BLOCK_CFG, 32'h0000_0000);
		rd(10'h3FF, 32'h0000_0000);
		chk(32'({pdClk, pdDly}), 32'h0000_FCC1);
	endtask
	task automatic lat(input logic [31:0] e, input logic [31:0] u);
		int n;
		logic [31:0] q;
		n = 0;
		wr(IDX_LAT_CTRL, 32'h0000_0031);
		do begin
			wb(1'b0, IDX_STATUS, 32'h0000_0000, 4'hF, q);
			n++;
		end while ((q[0] !== 1'b0 || q[2] !== 1'b1) && n < 100);
		chk(32'({q[2], q[0]}), 32'h0000_0002);
		chk(32'(q[1]), 32'(u == 0));
		rd(IDX_LAT_RESULT, e);
		rd(IDX_LAT_UNC, u);
	endtask
	task automatic t_latency();
		lat(el(12483, 1, 1, 192), 32'h0000_0000);
		wr(IDX_CHAN_SEL, 32'h0000_0005);
		wr(IDX_CHAN_CFG, 32'h0000_00BF);
		rd(IDX_CHAN_CFG, 32'h0000_00BC);
		wr(IDX_COMB_CFG, 32'h0001_0001);
		wr(IDX_PD_DELAY, 32'h0000_0FC1);
		wr(IDX_RATE0, 32'h0002_0003);
		lat(el(15747, 3, 2, 1008), 32'h0000_0020);
		chk(32'({fine, coarse}), 32'h0001_0001);
	endtask
	task automatic t_sync();
		int n;
		logic [3:0] e;
		int reads;
		wr(IDX_SYNC_CFG, 32'h0000_0005);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (n = 0; n < 300 && fifoRel === 4'h0; n++) begin
			@(posedge clk);
			#1;
		end
		chk(32'(fifoRel), 32'h0000_0005);
		chk(32'({d16, symRd & 4'h5}), 32'h0000_0015);
		chk(32'(chSync[5:4]), 32'h0000_0002);
		e = 4'h0;
		reads = 0;
		repeat (96) begin
			@(posedge clk);
			#1;
			e = e | fifoRel;
			reads += int'(symRd[0]);
		end
		chk(32'(e), 32'h0000_0000);
		chk(32'(reads), 32'h0000_0002);
		rd(IDX_STATUS, 32'h0000_000C);
		wr(IDX_CHAN_CFG, 32'h0000_00C0);
		settle();
		chk(32'({chClk[5:4], chSync[5]}), 32'h0000_0002);
	endtask
	task automatic t_power();
		wr(IDX_BLOCK_CFG, 32'h0000_0002);
		settle();
		chk(32'({blkClk, combClk}), 32'h000D_FF0F);
		chk(chClk[63:32], 32'h0000_0000);
		wr(IDX_PD_CTRL, 32'h0000_0500, 4'b0010);
		wr(IDX_PD_CTRL, 32'h0000_0080, 4'b0001);
		rd(IDX_PD_CTRL, 32'h0000_0580);
		chk(32'(pdClk), 32'h0000_0004);
	endtask
	task automatic t_reset();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (40) begin
			@(posedge clk);
			#1;
			chk(32'({d16, halfTick}), 32'h0000_0000);
		end
		@(posedge clk);
		resetn <= 1'b1;
		t_defaults();
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		resetn = 1'b0;
		{cyc, stb, we, go} = 4'h0;
		adr = '0;
		sel = 4'h0;
		datI = 32'h0000_0000;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		t_defaults();
		t_latency();
		t_sync();
		t_power();
		t_reset();
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
